// [design/porseq_pkg.sv]
// shared constants and carrier types for the power-on reset sequencer
package porseq_pkg;

  localparam int CLK_HZ = 40000000;
  // power-up release delay, in microseconds
  localparam int RELEASE_DELAY_US = 100;
  localparam int RELEASE_DELAY_CYC = (RELEASE_DELAY_US * (CLK_HZ / 1000000));

  // register byte addresses on the bus
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_MON = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

  // reset cause register fields
  localparam int CAUSE_OTHER_BIT = 0;
  localparam int CAUSE_POWER_UP_BIT = 1;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  // monitor enable register fields
  localparam int MON_PRIMARY_BIT = 0;
  localparam int MON_SECONDARY_BIT = 1;
  localparam logic [1:0] MON_RESET = 2'h0;

  // interrupt status fields
  localparam int IRQ_RELEASE_BIT = 0;
  localparam int IRQ_SUPPLY_LOSS_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  typedef enum {
    PORSEQ_ST_HOLD,
    PORSEQ_ST_DELAY,
    PORSEQ_ST_RUN
  } porseq_state_t;

  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
    logic req;
  } porseq_bus_req_t;

endpackage

// [design/porseq_sync.sv]
// three-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module porseq_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // a change counts only once two late stages agree
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// [design/porseq_delay.sv]
// power-up delay counter, restarted whenever supply drops
`timescale 1ns/1ps
`default_nettype none
module porseq_delay #(
  parameter int CYCLES = 4000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      done <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        count <= '0;
        done <= 1'b0;
      end else if (count == LAST) begin
        done <= 1'b1;
      end else begin
        count <= count + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// [design/porseq_top.sv]
// power-on reset sequencer with wishbone status and control registers
//
// Overview of operation
// - while supply is not good, hold internal reset and drive reset pin low
// - after supply rises past threshold, wait release delay before releasing
// - leaving power-on reset sets the power-up cause flag, bit 1
// - with power-up flag set, other cause flags are undefined for software
// - any non-power-on reset clears the power-up cause flag
// - processor starts fetching at address 0x0000 after any reset
// - data memory is not initialised by the power-on sequence
// - after power-on reset both supply monitors are enabled
`timescale 1ns/1ps
`default_nettype none
module porseq_top #(
  parameter int RELEASE_CYC = porseq_pkg::RELEASE_DELAY_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic SUPPLY_GOOD,
  input wire logic OTHER_RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic CORE_RESET,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE_N,
  output logic [15:0] RESET_VECTOR,
  output logic SUPPLY_MONITOR_PRIMARY,
  output logic SUPPLY_MONITOR_SECONDARY,
  output logic IRQ
);
  logic supply_ok;
  logic other_rst;
  logic delay_done;
  porseq_pkg::porseq_state_t state;
  porseq_pkg::porseq_state_t next_state;
  porseq_pkg::porseq_bus_req_t bus;
  logic [7:0] reset_cause_register;
  logic [1:0] mon_en;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic other_rst_q;
  logic other_rise;
  logic hold_prev;
  logic release_evt;
  logic loss_evt;
  logic wr;
  logic [31:0] rd;

  porseq_sync u_sync_supply (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .d(SUPPLY_GOOD),
    .q(supply_ok)
  );

  porseq_sync u_sync_other (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .d(OTHER_RESET),
    .q(other_rst)
  );

  porseq_delay #(
    .CYCLES(RELEASE_CYC)
  ) u_delay (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .run(state == porseq_pkg::PORSEQ_ST_DELAY),
    .done(delay_done)
  );

  assign bus.adr = WB_ADR_I;
  assign bus.we = WB_WE_I;
  assign bus.sel = WB_SEL_I;
  assign bus.dat = WB_DAT_I;
  assign bus.req = WB_CYC_I & WB_STB_I;
  assign wr = bus.req & bus.we & ~WB_ACK_O;

  always_comb begin
    next_state = state;
    case (state)
      porseq_pkg::PORSEQ_ST_HOLD: begin
        if (supply_ok) begin
          next_state = porseq_pkg::PORSEQ_ST_DELAY;
        end
      end
      porseq_pkg::PORSEQ_ST_DELAY: begin
        if (!supply_ok) begin
          next_state = porseq_pkg::PORSEQ_ST_HOLD;
        end else if (delay_done) begin
          next_state = porseq_pkg::PORSEQ_ST_RUN;
        end
      end
      porseq_pkg::PORSEQ_ST_RUN: begin
        if (!supply_ok) begin
          next_state = porseq_pkg::PORSEQ_ST_HOLD;
        end
      end
      default: next_state = porseq_pkg::PORSEQ_ST_HOLD;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= porseq_pkg::PORSEQ_ST_HOLD;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // hold core and pull pin low until running
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CORE_RESET <= 1'b1;
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE_N <= 1'b0;
    end else if (CE) begin
      CORE_RESET <= (next_state != porseq_pkg::PORSEQ_ST_RUN);
      RESET_PIN_OUT <= 1'b0;
      // open drain: enable low means pin is pulled low
      RESET_PIN_OE_N <= (next_state == porseq_pkg::PORSEQ_ST_RUN);
    end
  end

  // fixed start address for every reset source
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RESET_VECTOR <= porseq_pkg::RESET_VECTOR;
    end else if (CE) begin
      RESET_VECTOR <= porseq_pkg::RESET_VECTOR;
    end
  end

  // no memory clearing is done; the core sees whatever ram holds

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      other_rst_q <= 1'b0;
      hold_prev <= 1'b1;
    end else if (CE) begin
      other_rst_q <= other_rst;
      hold_prev <= CORE_RESET;
    end
  end
  assign other_rise = other_rst & ~other_rst_q;
  assign release_evt = hold_prev & ~CORE_RESET;
  assign loss_evt = (state != porseq_pkg::PORSEQ_ST_HOLD) &
    (next_state == porseq_pkg::PORSEQ_ST_HOLD);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      reset_cause_register <= porseq_pkg::CAUSE_RESET;
    end else if (CE) begin
      if (release_evt) begin
        reset_cause_register[porseq_pkg::CAUSE_POWER_UP_BIT] <= 1'b1;
      end else if (other_rise) begin
        reset_cause_register[porseq_pkg::CAUSE_POWER_UP_BIT] <= 1'b0;
        reset_cause_register[porseq_pkg::CAUSE_OTHER_BIT] <= 1'b1;
      end
      // other flags left as they were, not defined after power-up
    end
  end

  // enable both monitors on release; software may clear them later
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mon_en <= porseq_pkg::MON_RESET;
    end else if (CE) begin
      if (release_evt) begin
        mon_en <= 2'h3;
      end else if (wr && bus.adr == porseq_pkg::ADDR_MON && bus.sel[0]) begin
        mon_en <= bus.dat[1:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SUPPLY_MONITOR_PRIMARY <= 1'b0;
      SUPPLY_MONITOR_SECONDARY <= 1'b0;
    end else if (CE) begin
      SUPPLY_MONITOR_PRIMARY <= mon_en[porseq_pkg::MON_PRIMARY_BIT];
      SUPPLY_MONITOR_SECONDARY <= mon_en[porseq_pkg::MON_SECONDARY_BIT];
    end
  end

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_stat <= porseq_pkg::IRQ_RESET;
      irq_mask <= porseq_pkg::IRQ_RESET;
    end else if (CE) begin
      if (wr && bus.adr == porseq_pkg::ADDR_IRQ_MASK && bus.sel[0]) begin
        irq_mask <= bus.dat[1:0];
      end
      if (wr && bus.adr == porseq_pkg::ADDR_IRQ_STAT && bus.sel[0]) begin
        irq_stat <= (irq_stat & ~bus.dat[1:0]) | {loss_evt, release_evt};
      end else begin
        irq_stat <= irq_stat | {loss_evt, release_evt};
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  always_comb begin
    rd = 32'h0000_0000;
    case (bus.adr)
      porseq_pkg::ADDR_CAUSE: rd[7:0] = reset_cause_register;
      porseq_pkg::ADDR_MON: rd[1:0] = mon_en;
      porseq_pkg::ADDR_IRQ_STAT: rd[1:0] = irq_stat;
      porseq_pkg::ADDR_IRQ_MASK: rd[1:0] = irq_mask;
      default: rd = 32'h0000_0000;
    endcase
  end

  // one-cycle-late ack; unmapped reads give zero, writes ignored
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE) begin
      WB_ACK_O <= bus.req & ~WB_ACK_O;
      WB_DAT_O <= rd;
    end
  end
endmodule
`default_nettype wire

// [verification/porseq_props.sv]
// assertion checker on the sequencer's top-level ports
`timescale 1ns/1ps
`default_nettype none
module porseq_props #(
  parameter int RELEASE_CYC = 8
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SUPPLY_GOOD,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic CORE_RESET,
  input wire logic RESET_PIN_OUT,
  input wire logic RESET_PIN_OE_N,
  input wire logic [15:0] RESET_VECTOR,
  input wire logic SUPPLY_MONITOR_PRIMARY,
  input wire logic SUPPLY_MONITOR_SECONDARY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // eight cycles cover the input synchroniser and the output register
  hold_in_reset_a: assert property (
    !SUPPLY_GOOD [*8] |-> CORE_RESET && !RESET_PIN_OE_N)
    else $error("core not held while supply low");
  pin_tracks_core_a: assert property (
    RESET_PIN_OE_N == !CORE_RESET) else $error("pin and core disagree");
  pin_low_a: assert property (
    RESET_PIN_OUT == 1'b0) else $error("reset pin level not low");
  release_delay_a: assert property (
    $fell(CORE_RESET) |-> $past(SUPPLY_GOOD, RELEASE_CYC))
    else $error("released before delay");
  monitors_on_a: assert property (
    $fell(CORE_RESET) |-> ##[0:2]
      SUPPLY_MONITOR_PRIMARY && SUPPLY_MONITOR_SECONDARY)
    else $error("monitors not enabled");
  vector_zero_a: assert property (
    RESET_VECTOR == 16'h0000) else $error("start address not zero");
  ack_pulse_a: assert property (
    WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  ack_next_a: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  ack_cause_a: assert property (
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
endmodule
`default_nettype wire

// [verification/porseq_core_model.sv]
// behavioural core that the sequencer holds in reset
`timescale 1ns/1ps
`default_nettype none
module porseq_core_model (
  input wire logic clk,
  input wire logic core_reset,
  input wire logic [15:0] vector,
  output logic [15:0] first_addr
);
  always_ff @(posedge clk) begin
    if (core_reset) begin
      first_addr <= vector;
    end
  end
  // memory left undefined
  // no data memory is modelled, so nothing may rely on its contents
endmodule
`default_nettype wire

// [verification/tb_porseq_top.sv]
// self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_porseq_top;
  localparam int RELEASE_CYC = 8;
  logic clk = 0, rst = 1, sg = 0, orst = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0, sel = 4'hf, s;
  logic [31:0] dat = 32'h0, q, rd, d, mexp = 32'h3;
  logic [15:0] vec, first;
  logic ack, core, pout, oe_n, mon0, mon1, irq;
  int n_mismatch = 0, tests_run = 0, seed = 32'h875f, n;
  initial forever #12.5 clk = ~clk;
  porseq_top #(.RELEASE_CYC(RELEASE_CYC)) dut (.SYS_CLK(clk), .RST(rst),
    .CE(1'b1), .SUPPLY_GOOD(sg), .OTHER_RESET(orst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack), .CORE_RESET(core),
    .RESET_PIN_OUT(pout), .RESET_PIN_OE_N(oe_n), .RESET_VECTOR(vec),
    .SUPPLY_MONITOR_PRIMARY(mon0), .SUPPLY_MONITOR_SECONDARY(mon1),
    .IRQ(irq));
  porseq_core_model core_m (.clk(clk), .core_reset(core), .vector(vec),
    .first_addr(first));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] v,
           input logic [3:0] m);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    sel <= m;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task wait_core(input logic lvl);
    n = 0;
    while (core !== lvl && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (core !== lvl) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // a write lands only when byte lane 0 is selected
  function automatic logic [31:0] mon_next(logic [31:0] o, v, logic [3:0] m);
    return m[0] ? {30'h0, v[1:0]} : o;
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'({core, oe_n, pout}), 32'h4);
    $display("hold done");
    sg <= 1'b1;
    repeat (2 + ($random(seed) & 3)) @(posedge clk);
    sg <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(core), 32'h1);
    sg <= 1'b1;
    wait_core(1'b0);
    chk(32'(n >= RELEASE_CYC && n <= RELEASE_CYC + 12), 32'h1);
    chk({15'h0, oe_n, first}, 32'h10000);
    repeat (2) @(posedge clk);
    chk(32'({mon0, mon1, irq}), 32'h6);
    bus(1'b0, porseq_pkg::ADDR_CAUSE, 32'h0, 4'hf);
    chk(q & 32'h2, 32'h2);
    // the early supply glitch left the delay state, so loss is flagged too
    bus(1'b0, porseq_pkg::ADDR_IRQ_STAT, 32'h0, 4'hf);
    chk(q, 32'h3);
    bus(1'b1, porseq_pkg::ADDR_IRQ_MASK, 32'h1, 4'hf);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, porseq_pkg::ADDR_IRQ_STAT, 32'h1, 4'hf);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, 4'h2, 32'hffffffff, 4'hf);
    bus(1'b0, 4'h2, 32'h0, 4'hf);
    chk(q, 32'h0);
    $display("release and registers done");
    repeat (4) begin
      d = $random(seed);
      s = 4'($random(seed));
      bus(1'b1, porseq_pkg::ADDR_MON, d, s);
      mexp = mon_next(mexp, d, s);
      bus(1'b0, porseq_pkg::ADDR_MON, 32'h0, 4'hf);
      chk(q, mexp);
      chk(32'({mon1, mon0}), mexp);
    end
    orst <= 1'b1;
    repeat (8) @(posedge clk);
    orst <= 1'b0;
    repeat (8) @(posedge clk);
    wait_core(1'b0);
    bus(1'b0, porseq_pkg::ADDR_CAUSE, 32'h0, 4'hf);
    chk(q & 32'h3, 32'h1);
    sg <= 1'b0;
    wait_core(1'b1);
    chk(32'({oe_n, pout}), 32'h0);
    sg <= 1'b1;
    wait_core(1'b0);
    bus(1'b0, porseq_pkg::ADDR_CAUSE, 32'h0, 4'hf);
    chk(q & 32'h2, 32'h2);
    bus(1'b0, porseq_pkg::ADDR_MON, 32'h0, 4'hf);
    chk(q, 32'h3);
    $display("other reset and supply loss done");
    tally_and_finish();
  end
endmodule
bind porseq_top porseq_props #(.RELEASE_CYC(RELEASE_CYC)) u_props (.SYS_CLK,
  .RST, .SUPPLY_GOOD, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .CORE_RESET,
  .RESET_PIN_OUT, .RESET_PIN_OE_N, .RESET_VECTOR, .SUPPLY_MONITOR_PRIMARY,
  .SUPPLY_MONITOR_SECONDARY);
`default_nettype wire
